// ---- rtl/mq_write_pkg.sv ----
package mq_write_pkg;

  // ----------------------------------------
  // Widths and fields
  // ----------------------------------------
  localparam int ADDR_W       = 5;
  localparam int QSEL_W       = 2;
  localparam int DEV_W        = 3;
  localparam int QSEL_LSB     = 0;
  localparam int DEV_LSB      = 2;
  localparam int NUM_QUEUES   = 4;
  localparam int DATA_W       = 36;
  localparam int CFG_LEN      = 16;
  localparam int CFG_DEV_LSB  = 0;
  localparam int CFG_POLL_BIT = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [QSEL_W-1:0] QSEL_RST = 2'h0;
  localparam logic [DEV_W-1:0]  DEV_RST  = 3'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic              strobe;
    logic [ADDR_W-1:0] addr;
  } addr_req_t;

  typedef struct packed {
    logic              valid;
    logic [QSEL_W-1:0] queue;
    logic [DATA_W-1:0] data;
  } wr_word_t;

  typedef enum logic [2:0] {
    CFG_LOAD = 3'h1,
    CFG_DONE = 3'h2,
    CFG_PASS = 3'h4
  } cfg_state_t;

endpackage : mq_write_pkg

// ---- rtl/serial_cfg_chain.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_cfg_chain #(
  parameter int LEN = 16
) (
  // Clock and reset
  input  wire logic           mclk_i,
  input  wire logic           srst_i,
  // Serial chain
  input  wire logic           sclk_rise_i,
  input  wire logic           chain_en_n_i,
  input  wire logic           serial_in_i,
  output logic                serial_out_o,
  output logic                config_done_out_o,
  // Setup contents
  output logic [LEN-1:0]      setup_o,
  output logic                loaded_o
);
  import mq_write_pkg::*;

  cfg_state_t       state;
  cfg_state_t       next_state;
  logic [LEN-1:0]   next_setup;
  logic [$clog2(LEN+1)-1:0] count;
  logic [$clog2(LEN+1)-1:0] next_count;
  logic             next_sout;
  logic             next_done;

  always_comb begin
    next_state = state;
    next_setup = setup_o;
    next_count = count;
    next_sout  = serial_out_o;
    next_done  = 1'b1;
    unique case (state)
      CFG_LOAD: begin
        if (sclk_rise_i && !chain_en_n_i) begin
          next_setup = {serial_in_i, setup_o[LEN-1:1]};
          next_count = count + 1'b1;
          if (count == ($clog2(LEN+1))'(LEN - 1)) begin
            next_state = CFG_DONE;
          end
        end
      end
      CFG_DONE, CFG_PASS: begin
        next_done  = chain_en_n_i;
        next_state = chain_en_n_i ? CFG_DONE : CFG_PASS;
        if (sclk_rise_i) begin
          next_sout = serial_in_i;
        end
      end
      default: next_state = CFG_LOAD;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state        <= CFG_LOAD;
      setup_o      <= '0;
      count        <= '0;
      serial_out_o <= 1'b0;
      config_done_out_o <= 1'b1;
    end else begin
      state        <= next_state;
      setup_o      <= next_setup;
      count        <= next_count;
      serial_out_o <= next_sout;
      config_done_out_o <= next_done;
    end
  end

  assign loaded_o = (state != CFG_LOAD);

endmodule : serial_cfg_chain
`default_nettype wire

// ---- rtl/multiqueue_write_port_select.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - After loading, config done output follows the chain enable input.
// - Writes are accepted only once config done has gone low.
// - Serial bit sampled on each serial clock rise while enable is low.
// - Setup registers are a shift register loaded one bit at a time.
// - Once loaded, serial input passes to serial output, whatever the done level.
// - Strobe on write clock edge captures address as next write target.
// - Write enable low stores input word into selected queue.
// - Queue selection works whatever the write enable level.
// - Selection edge and next edge still write the old queue.
// - From the second edge after selection, writes go to new queue.
// - Address is five bits: low two pick queue, high three device.
// - Selection taken only when high bits match own device id.
// - Strobed flag mode: flag strobe picks flag device from high bits.
// - Polled mode steps flag bus, makes sync; flags registered.
// - Flag polling and flag device select need no write enable.
module multiqueue_write_port_select #(
  parameter int DATA_W = mq_write_pkg::DATA_W,
  parameter int NDEV   = 8
) (
  // Clock and reset
  input  wire logic                             mclk_i,
  input  wire logic                             srst_i,
  // Serial configuration
  input  wire logic                             serial_config_clock_i,
  input  wire logic                             config_chain_in_enable_i,
  input  wire logic                             serial_config_in_i,
  output logic                                  serial_config_out_o,
  output logic                                  config_done_out_o,
  // Write port
  input  wire mq_write_pkg::addr_req_t          addr_req_i,
  input  wire logic                             almost_full_bus_strobe_i,
  input  wire logic                             write_enable_n_i,
  input  wire logic [DATA_W-1:0]                write_data_in_i,
  output mq_write_pkg::wr_word_t                wr_word_o,
  output logic [mq_write_pkg::QSEL_W-1:0]       write_queue_o,
  // Queue status from storage
  input  wire logic [mq_write_pkg::NUM_QUEUES-1:0] queue_full_n_i,
  input  wire logic [mq_write_pkg::NUM_QUEUES-1:0] queue_almost_full_n_i,
  // Flags
  output logic                                  full_flag_n_o,
  output logic                                  almost_full_flag_n_o,
  output logic [mq_write_pkg::NUM_QUEUES-1:0]   almost_full_flag_bus_o,
  output logic                                  almost_full_flag_bus_oe_o,
  output logic                                  almost_full_poll_sync_o
);
  import mq_write_pkg::*;

  // ----------------------------------------
  // Serial clock edge and configuration
  // ----------------------------------------
  logic               sclk_q;
  logic               sclk_rise;
  logic [CFG_LEN-1:0] setup;
  logic               loaded;
  logic               ready;
  logic [DEV_W-1:0]   own_id;
  logic               poll_mode;

  assign sclk_rise = serial_config_clock_i & ~sclk_q;

  serial_cfg_chain #(
    .LEN (CFG_LEN)
  ) u_cfg (
    .mclk_i            (mclk_i),
    .srst_i            (srst_i),
    .sclk_rise_i       (sclk_rise),
    .chain_en_n_i      (config_chain_in_enable_i),
    .serial_in_i       (serial_config_in_i),
    .serial_out_o      (serial_config_out_o),
    .config_done_out_o (config_done_out_o),
    .setup_o           (setup),
    .loaded_o          (loaded)
  );

  assign own_id    = setup[CFG_DEV_LSB +: DEV_W];
  assign poll_mode = setup[CFG_POLL_BIT];

  function automatic logic [DEV_W-1:0] dev_field(input logic [ADDR_W-1:0] a);
    dev_field = a[DEV_LSB +: DEV_W];
  endfunction : dev_field

  // ----------------------------------------
  // Write queue selection and data path
  // ----------------------------------------
  logic [QSEL_W-1:0] pend_q;
  logic              pend_v;
  logic [QSEL_W-1:0] next_queue;
  logic [QSEL_W-1:0] next_pend_q;
  logic              next_pend_v;
  logic              next_ready;
  wr_word_t          next_word;
  logic              sel_hit;

  // Selection ignores write enable
  assign sel_hit = ready && addr_req_i.strobe && !almost_full_bus_strobe_i
                   && (dev_field(addr_req_i.addr) == own_id);

  always_comb begin
    next_ready  = ready | (loaded & ~config_done_out_o);
    next_queue  = write_queue_o;
    next_pend_q = pend_q;
    next_pend_v = 1'b0;
    if (pend_v) begin
      next_queue = pend_q;
    end
    if (sel_hit) begin
      next_pend_q = addr_req_i.addr[QSEL_LSB +: QSEL_W];
      next_pend_v = 1'b1;
    end
    next_word.valid = ready && !write_enable_n_i;
    next_word.queue = write_queue_o;
    next_word.data  = write_data_in_i;
  end

  // ----------------------------------------
  // Flag bus: strobed or polled
  // ----------------------------------------
  logic [DEV_W-1:0] flag_dev;
  logic [DEV_W-1:0] next_flag_dev;
  logic             next_sync;
  logic             next_oe;
  logic [NUM_QUEUES-1:0] next_bus;

  always_comb begin
    next_flag_dev = flag_dev;
    if (poll_mode) begin
      next_flag_dev = (flag_dev == DEV_W'(NDEV - 1)) ? DEV_RST : flag_dev + 1'b1;
    end else if (almost_full_bus_strobe_i) begin
      next_flag_dev = dev_field(addr_req_i.addr);
    end
    next_sync = poll_mode && (next_flag_dev == DEV_RST);
    next_oe   = ready && (next_flag_dev == own_id);
    next_bus  = next_oe ? queue_almost_full_n_i : '1;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sclk_q                    <= 1'b0;
      ready                     <= 1'b0;
      write_queue_o             <= QSEL_RST;
      pend_q                    <= QSEL_RST;
      pend_v                    <= 1'b0;
      wr_word_o                 <= '0;
      flag_dev                  <= DEV_RST;
      almost_full_poll_sync_o   <= 1'b0;
      almost_full_flag_bus_oe_o <= 1'b0;
      almost_full_flag_bus_o    <= '1;
      full_flag_n_o             <= 1'b1;
      almost_full_flag_n_o      <= 1'b1;
    end else begin
      sclk_q                    <= serial_config_clock_i;
      ready                     <= next_ready;
      write_queue_o             <= next_queue;
      pend_q                    <= next_pend_q;
      pend_v                    <= next_pend_v;
      wr_word_o                 <= next_word;
      flag_dev                  <= next_flag_dev;
      almost_full_poll_sync_o   <= next_sync;
      almost_full_flag_bus_oe_o <= next_oe;
      almost_full_flag_bus_o    <= next_bus;
      full_flag_n_o             <= queue_full_n_i[next_queue];
      almost_full_flag_n_o      <= queue_almost_full_n_i[next_queue];
    end
  end

endmodule : multiqueue_write_port_select
`default_nettype wire

// ---- verification/multiqueue_write_port_select_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module mqw_checker
  import mq_write_pkg::*;
#(parameter logic [2:0] ID = 3'h5) (
  // Clock, reset, serial chain
  input wire logic                                mclk_i,
  input wire logic                                srst_i,
  input wire logic                                serial_config_clock_i,
  input wire logic                                config_chain_in_enable_i,
  input wire logic                                serial_config_in_i,
  input wire logic                                serial_config_out_o,
  input wire logic                                config_done_out_o,
  // Write port
  input wire mq_write_pkg::addr_req_t             addr_req_i,
  input wire logic                                almost_full_bus_strobe_i,
  input wire logic                                write_enable_n_i,
  input wire logic [mq_write_pkg::DATA_W-1:0]     write_data_in_i,
  input wire mq_write_pkg::wr_word_t              wr_word_o,
  input wire logic [mq_write_pkg::QSEL_W-1:0]     write_queue_o,
  input wire logic                                almost_full_flag_bus_oe_o
);
  logic rdy;
  logic next_rdy;
  logic sel_m;
  // Ready once done has been seen low
  always_comb next_rdy = rdy | !config_done_out_o;
  always_ff @(posedge mclk_i) begin
    rdy <= srst_i ? 1'b0 : next_rdy;
  end
  assign sel_m = rdy && addr_req_i.strobe && !almost_full_bus_strobe_i && addr_req_i.addr[4:2] == ID;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_done_follow: assert property (
    rdy |-> config_done_out_o == $past(config_chain_in_enable_i)) else $error("done not following enable");
  a_no_early_write: assert property (
    config_done_out_o && !rdy |=> !wr_word_o.valid) else $error("write before configuration");
  a_word_taken: assert property (
    rdy && !write_enable_n_i |=> wr_word_o.valid && wr_word_o.data == $past(write_data_in_i))
    else $error("enabled word lost");
  a_queue_tag: assert property (
    wr_word_o.valid |-> wr_word_o.queue == $past(write_queue_o)) else $error("word tagged with wrong queue");
  a_select_lag: assert property (
    sel_m |-> ##2 write_queue_o == $past(addr_req_i.addr[1:0], 2)) else $error("selection lag wrong");
  a_select_hold: assert property (
    !sel_m |-> ##2 $stable(write_queue_o)) else $error("selection changed without strobe");
  a_sout_pass: assert property (
    rdy && !config_done_out_o && $rose(serial_config_clock_i) |=> serial_config_out_o == $past(serial_config_in_i))
    else $error("serial pass-through wrong");
  a_flag_pick: assert property (
    rdy && almost_full_bus_strobe_i && !addr_req_i.strobe |=>
      almost_full_flag_bus_oe_o == ($past(addr_req_i.addr[4:2]) == ID)) else $error("flag device select wrong");
  c_select: cover property (sel_m);
  c_write: cover property (wr_word_o.valid);
  c_flag: cover property (rdy && almost_full_bus_strobe_i);
endmodule : mqw_checker
bind multiqueue_write_port_select mqw_checker #(.ID(3'h5)) u_chk (.mclk_i(mclk_i), .srst_i(srst_i),
  .serial_config_clock_i(serial_config_clock_i), .config_chain_in_enable_i(config_chain_in_enable_i),
  .serial_config_in_i(serial_config_in_i), .serial_config_out_o(serial_config_out_o),
  .config_done_out_o(config_done_out_o), .addr_req_i(addr_req_i), .almost_full_bus_strobe_i(almost_full_bus_strobe_i),
  .write_enable_n_i(write_enable_n_i), .write_data_in_i(write_data_in_i), .wr_word_o(wr_word_o),
  .write_queue_o(write_queue_o), .almost_full_flag_bus_oe_o(almost_full_flag_bus_oe_o));
`default_nettype wire

// ---- verification/cfg_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfg_master_model (
  // Clock
  input  wire logic mclk_i,
  // Serial drive
  output logic      sclk_o,
  output logic      sdata_o
);
  initial begin
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
  end
  // First bit first; clock idles low, data inverted after frame
  task automatic send(input logic [15:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i) #1;
      sclk_o  = 1'b0;
      sdata_o = w[i];
      repeat (3) @(posedge mclk_i);
      #1 sclk_o = 1'b1;
      repeat (3) @(posedge mclk_i);
    end
    @(posedge mclk_i) #1;
    sclk_o  = 1'b0;
    sdata_o = ~sdata_o;
  endtask : send
endmodule : cfg_master_model
`default_nettype wire

// ---- verification/multiqueue_write_port_select_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module multiqueue_write_port_select_tb;
  import mq_write_pkg::*;
  localparam logic [2:0] ID = 3'h5;
  logic mclk_i = 1'b0, srst_i = 1'b1, en_n = 1'b1, almost_full_bus_strobe = 1'b0, we_n = 1'b1, rdy = 1'b0;
  logic sclk, sdat, sout, done;
  addr_req_t req = '0;
  logic [DATA_W-1:0] din = '0;
  logic [3:0] full_n = 4'hf, af_n = 4'hf;
  wr_word_t word;
  logic [37:0] e;
  logic [31:0] r;
  logic [15:0] b;
  logic [1:0] wq;
  logic ffn, afn, oe, sync, sclk_p = 1'b0, x_ff = 1'b1, x_af = 1'b1, x_oe = 1'b0, x_sync = 1'b0;
  logic [3:0] bus, x_bus = 4'hf;
  logic [CFG_LEN-1:0] setup = '0;
  int nbits = 0, fdev = 0, nq = 0;
  int n_mismatch = 0, comparisons = 0, cur = 0, p0 = -1, p1 = -1;
  logic [37:0] expq[$];
  always #10 mclk_i = ~mclk_i;
  multiqueue_write_port_select DUT (.mclk_i(mclk_i), .srst_i(srst_i), .serial_config_clock_i(sclk),
    .config_chain_in_enable_i(en_n), .serial_config_in_i(sdat), .serial_config_out_o(sout),
    .config_done_out_o(done), .addr_req_i(req), .almost_full_bus_strobe_i(almost_full_bus_strobe), .write_enable_n_i(we_n),
    .write_data_in_i(din), .wr_word_o(word), .write_queue_o(wq), .queue_full_n_i(full_n),
    .queue_almost_full_n_i(af_n), .full_flag_n_o(ffn), .almost_full_flag_n_o(afn), .almost_full_flag_bus_o(bus),
    .almost_full_flag_bus_oe_o(oe), .almost_full_poll_sync_o(sync));
  cfg_master_model PM (.mclk_i(mclk_i), .sclk_o(sclk), .sdata_o(sdat));
  // ----------------------------------------
  // Reference model of queue selection
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (word.valid && expq.size() == 0) `CHK("spurious word", 1'b0, word.valid)
    else if (word.valid) begin
      e = expq.pop_front();
      `CHK("word", e, {word.queue, word.data})
    end
    if (!srst_i) begin
      `CHK("full flag", x_ff, ffn)
      `CHK("almost full flag", x_af, afn)
      `CHK("flag bus", x_bus, bus)
      `CHK("flag bus enable", x_oe, oe)
      `CHK("poll sync", x_sync, sync)
      if (p1 >= 0) cur = p1;
      `CHK("write queue", cur[1:0], wq)
      if (rdy && !we_n) expq.push_back({cur[1:0], din});
      p1 = p0;
      p0 = (rdy && req.strobe && !almost_full_bus_strobe && req.addr[4:2] == ID) ? int'(req.addr[1:0]) : -1;
      nq = (p1 >= 0) ? p1 : cur;
      x_ff = full_n[nq];
      x_af = af_n[nq];
      if (setup[CFG_POLL_BIT]) fdev = (fdev + 1) % 8;
      else if (almost_full_bus_strobe) fdev = req.addr[4:2];
      x_sync = setup[CFG_POLL_BIT] && fdev == 0;
      x_oe = rdy && fdev == ID;
      x_bus = x_oe ? af_n : 4'hf;
      if (sclk && !sclk_p && !en_n && nbits < CFG_LEN) begin
        setup = {sdat, setup[CFG_LEN-1:1]};
        nbits++;
      end
      sclk_p = sclk;
      rdy = rdy | !done;
    end else begin
      expq.delete();
      rdy = 1'b0;
      cur = 0;
      p0 = -1;
      p1 = -1;
      fdev = 0;
      setup = '0;
      nbits = 0;
      sclk_p = 1'b0;
      x_ff = 1'b1;
      x_af = 1'b1;
      x_bus = 4'hf;
      x_oe = 1'b0;
      x_sync = 1'b0;
    end
  end
  task automatic wait_done(input logic v);
    for (int k = 0; k < 8 && done !== v; k++) @(posedge mclk_i);
    #1 `CHK("config done", v, done)
  endtask : wait_done
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(20 * 5000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(99));
    repeat (4) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    `CHK("done at reset", 1'b1, done)
    we_n = 1'b0;
    repeat (5) @(posedge mclk_i);
    #1 we_n = 1'b1;
    en_n = 1'b0;
    PM.send({12'h000, 1'b0, ID}, 16);
    wait_done(1'b0);
    b = 16'($urandom);
    PM.send(b, 1);
    `CHK("serial out", b[0], sout)
    en_n = 1'b1;
    wait_done(1'b1);
    en_n = 1'b0;
    wait_done(1'b0);
    drive_random(400, 1'b1);
    srst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    `CHK("done after reset", 1'b1, done)
    PM.send({12'h000, 1'b1, ID}, 16);
    wait_done(1'b0);
    drive_random(200, 1'b0);
    tally_and_finish();
  end
  task automatic drive_random(input int n, input logic flag_strobes);
    repeat (n) begin
      @(posedge mclk_i) #1;
      r = $urandom;
      req.strobe = (r[2:0] == 3'h0);
      req.addr = {(r[4] ? ID : r[7:5]), r[9:8]};
      almost_full_bus_strobe = flag_strobes && (r[12:10] == 3'h0) && !req.strobe;
      we_n = r[14];
      din = {$urandom, r[3:0]};
      full_n = r[19:16];
      af_n = r[23:20];
    end
    @(posedge mclk_i) #1;
    req.strobe = 1'b0;
    almost_full_bus_strobe = 1'b0;
    we_n = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 `CHK("words left", 0, expq.size())
  endtask : drive_random
endmodule : multiqueue_write_port_select_tb
`default_nettype wire
